// ---- hw/sweep_pkg.sv ----
// Constants and types shared by the sweep sequencer design files
// Notes on behaviour
// - Both repeat sweep modes start converting channel 0 when start flag set.
// - Sweep mode 0 group selectable as channels 0-1, 0-3, 0-5, 0-7.
// - Sweep mode 0 converts each group channel from 0, storing each result.
// - Sweep mode 0 runs until start cleared; never raises completion request.
// - Sweep mode 1 converts priority group, one other channel, then restarts.
// - Sweep mode 1 stores each result, no completion request, runs until cleared.
// - Conversion clock is source divided by four, three, two, or undivided.
// - Trigger preloads approximation register with only bit 9, then decides bit 9.
// - Bits 8 down to 0 each set, compared, kept only if reference below input.
// - After bit 0, approximation value copies into the converted channel's result.
// - Reference follows value n: zero, else full times n/1024 minus full/2048.
// - In 8-bit resolution the upper eight approximation bits form the result.
package sweep_pkg;

   // =====================================================
   // Register map (word addresses on the plain port)
   localparam logic [3:0]  ADDR_CTRL    = 4'h0;
   localparam logic [3:0]  ADDR_STATUS  = 4'h1;
   localparam logic [3:0]  ADDR_RESULT0 = 4'h8;

   // =====================================================
   // Control register fields
   localparam int          CTRL_START_BIT = 0;
   localparam int          CTRL_MODE_BIT  = 1;
   localparam int          CTRL_GRP_LSB   = 2;
   localparam int          CTRL_DIV_LSB   = 4;
   localparam int          CTRL_RES8_BIT  = 6;
   localparam int          CTRL_WIDTH     = 7;
   localparam logic [6:0]  CTRL_RESET     = 7'h00;

   // =====================================================
   // Converter geometry
   localparam int          SAR_BITS   = 10;
   localparam int          NUM_CH     = 8;
   localparam logic [9:0]  SAR_PRESET = 10'h200;
   localparam logic [9:0]  RES_RESET  = 10'h000;
   localparam logic [2:0]  CH_ZERO    = 3'h0;
   localparam logic [2:0]  CH_LAST    = 3'h7;

   // Conversion clock divider settings
   typedef enum logic [1:0] {
      DIV_BY4,
      DIV_BY3,
      DIV_BY2,
      DIV_BY1
   } clk_div_t;

   typedef enum logic {
      SWEEP0,
      SWEEP1
   } sweep_mode_t;

endpackage

// ---- hw/conv_tick_gen.sv ----
// Conversion clock enable pulse generator
`timescale 1ns/100ps
module conv_tick_gen
   import sweep_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              arst_n,
   // Control
   input  wire sweep_pkg::clk_div_t div_sel,
   input  wire logic              run,
   // Tick
   output logic                   tick
);
   import sweep_pkg::*;

   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   logic       tick_ff;
   logic       nxt_tick;
   logic [1:0] terminal;

   always_comb begin
      case (div_sel)
         DIV_BY4: terminal = 2'h3;
         DIV_BY3: terminal = 2'h2;
         DIV_BY2: terminal = 2'h1;
         default: terminal = 2'h0;
      endcase
      nxt_tick = 1'b0;
      if (!run) begin
         nxt_cnt = 2'h0;
      end else if (cnt_ff >= terminal) begin
         nxt_cnt  = 2'h0;
         nxt_tick = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff  <= 2'h0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule

// ---- hw/sar_adc_sweep_sequencer.sv ----
// Repeat sweep sequencer and successive approximation control
`timescale 1ns/100ps
module sar_adc_sweep_sequencer
   import sweep_pkg::*;
(
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 arst_n,
   // Register port
   input  wire logic [3:0]           reg_addr,
   input  wire logic [15:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [15:0]               reg_rdata,
   // Analog front end
   input  wire logic                 cmp_ref_below,
   output logic [9:0]                dac_code,
   output logic [2:0]                mux_sel,
   output logic                      sample_en,
   // Status
   output logic                      conv_irq_req
);
   import sweep_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_BITS,
      ST_STORE
   } seq_state_t;

   // =====================================================
   // Helpers
   function automatic logic [2:0] group_last(input sweep_mode_t m, input logic [1:0] g);
      logic [2:0] r;
      r = 3'h0;
      if (m == SWEEP0) begin
         r = {g, 1'b1};
      end else begin
         r = {1'b0, g};
      end
      return r;
   endfunction

   // =====================================================
   // State
   logic [6:0]      ctrl_ff, nxt_ctrl;
   seq_state_t      st_ff, nxt_st;
   logic [9:0]      sar_ff, nxt_sar;
   logic [3:0]      bit_ff, nxt_bit;
   logic [2:0]      ch_ff, nxt_ch;
   logic [2:0]      extra_ff, nxt_extra;
   logic            in_extra_ff, nxt_in_extra;
   logic [9:0]      res_ff [NUM_CH];
   logic [9:0]      nxt_res [NUM_CH];
   logic [15:0]     rdata_ff, nxt_rdata;
   logic            cmp_s1_ff, cmp_s2_ff;
   logic [9:0]      dac_ff, nxt_dac;
   logic [2:0]      mux_ff, nxt_mux;
   logic            samp_ff, nxt_samp;
   logic            irq_ff;
   logic            tick;
   logic            start;
   sweep_mode_t     mode;
   logic [1:0]      grp;
   logic            res8;
   logic [2:0]      last_ch;
   logic [2:0]      nxt_x;
   logic [9:0]      trial;
   logic [9:0]      decided;

   assign start   = ctrl_ff[CTRL_START_BIT];
   assign mode    = sweep_mode_t'(ctrl_ff[CTRL_MODE_BIT]);
   assign grp     = ctrl_ff[CTRL_GRP_LSB +: 2];
   assign res8    = ctrl_ff[CTRL_RES8_BIT];
   assign last_ch = group_last(mode, grp);

   conv_tick_gen u_tick (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .div_sel (clk_div_t'(ctrl_ff[CTRL_DIV_LSB +: 2])),
      .run     (start),
      .tick    (tick)
   );

   // =====================================================
   // Comparator synchroniser (comparator is asynchronous to mclk)
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_s1_ff <= 1'b0;
         cmp_s2_ff <= 1'b0;
      end else begin
         cmp_s1_ff <= cmp_ref_below;
         cmp_s2_ff <= cmp_s1_ff;
      end
   end

   // =====================================================
   // Sequencer
   always_comb begin
      nxt_st       = st_ff;
      nxt_sar      = sar_ff;
      nxt_bit      = bit_ff;
      nxt_ch       = ch_ff;
      nxt_extra    = extra_ff;
      nxt_in_extra = in_extra_ff;
      nxt_res      = res_ff;
      trial        = 10'h000;
      decided      = sar_ff;
      nxt_x        = extra_ff;
      // Current bit decided from the comparator
      if (!cmp_s2_ff) begin
         decided[bit_ff] = 1'b0;
      end
      case (st_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_ch       = CH_ZERO;
               nxt_in_extra = 1'b0;
               // Fresh run: inserted channel restarts just above the group
               nxt_extra    = CH_ZERO;
               nxt_st       = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (tick) begin
               nxt_sar = SAR_PRESET;
               nxt_bit = 4'(SAR_BITS - 1);
               nxt_st  = ST_BITS;
            end
         end
         ST_BITS: begin
            // One tick per bit; at DIV_BY4 and DIV_BY3 the tick spacing lets the synchronised comparator settle, at DIV_BY2 and DIV_BY1 it does not
            if (tick) begin
               if (bit_ff == 4'h0) begin
                  nxt_sar = decided;
                  nxt_st  = ST_STORE;
               end else begin
                  trial                 = decided;
                  trial[bit_ff - 4'h1]  = 1'b1;
                  nxt_sar               = trial;
                  nxt_bit               = bit_ff - 4'h1;
               end
            end
         end
         ST_STORE: begin
            nxt_res[ch_ff] = res8 ? {2'b00, sar_ff[9:2]} : sar_ff;
            nxt_st         = ST_SAMPLE;
            if (mode == SWEEP0) begin
               nxt_ch = (ch_ff >= last_ch) ? CH_ZERO : ch_ff + 3'h1;
            end else if (in_extra_ff) begin
               nxt_in_extra = 1'b0;
               nxt_ch       = CH_ZERO;
               nxt_x        = (extra_ff >= CH_LAST) ? last_ch + 3'h1 : extra_ff + 3'h1;
               nxt_extra    = nxt_x;
            end else if (ch_ff >= last_ch) begin
               nxt_in_extra = 1'b1;
               nxt_ch       = (extra_ff > last_ch) ? extra_ff : last_ch + 3'h1;
               nxt_extra    = nxt_ch;
            end else begin
               nxt_ch = ch_ff + 3'h1;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
      if (!start) begin
         nxt_st = ST_IDLE;
      end
   end

   // Vref tracks the live approximation value
   always_comb begin
      nxt_dac  = nxt_sar;
      nxt_mux  = nxt_ch;
      nxt_samp = (nxt_st == ST_SAMPLE);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff       <= ST_IDLE;
         sar_ff      <= RES_RESET;
         bit_ff      <= 4'h0;
         ch_ff       <= CH_ZERO;
         extra_ff    <= CH_ZERO;
         in_extra_ff <= 1'b0;
         dac_ff      <= RES_RESET;
         mux_ff      <= CH_ZERO;
         samp_ff     <= 1'b0;
         irq_ff      <= 1'b0;
         for (int i = 0; i < NUM_CH; i++) begin
            res_ff[i] <= RES_RESET;
         end
      end else begin
         st_ff       <= nxt_st;
         sar_ff      <= nxt_sar;
         bit_ff      <= nxt_bit;
         ch_ff       <= nxt_ch;
         extra_ff    <= nxt_extra;
         in_extra_ff <= nxt_in_extra;
         dac_ff      <= nxt_dac;
         mux_ff      <= nxt_mux;
         samp_ff     <= nxt_samp;
         irq_ff      <= 1'b0;
         res_ff      <= nxt_res;
      end
   end

   // =====================================================
   // Register port
   always_comb begin
      nxt_ctrl  = ctrl_ff;
      nxt_rdata = 16'h0000;
      if (reg_wr && reg_addr == ADDR_CTRL) begin
         nxt_ctrl = reg_wdata[CTRL_WIDTH-1:0];
      end
      if (reg_rd) begin
         if (reg_addr == ADDR_CTRL) begin
            nxt_rdata = {9'h000, ctrl_ff};
         end else if (reg_addr == ADDR_STATUS) begin
            nxt_rdata = {10'h000, in_extra_ff, ch_ff, st_ff};
         end else if (reg_addr >= ADDR_RESULT0) begin
            nxt_rdata = {6'h00, res_ff[reg_addr[2:0]]};
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff  <= CTRL_RESET;
         rdata_ff <= 16'h0000;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata    = rdata_ff;
   assign dac_code     = dac_ff;
   assign mux_sel      = mux_ff;
   assign sample_en    = samp_ff;
   // Repeat sweep modes never raise completion
   assign conv_irq_req = irq_ff;
endmodule

// ---- tb/sweep_checker.sv ----
// Port-level assertions for the sweep sequencer
`timescale 1ns/100ps
module sweep_checker
   import sweep_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        arst_n,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Analog side and status
   input wire logic        cmp_ref_below,
   input wire logic [9:0]  dac_code,
   input wire logic [2:0]  mux_sel,
   input wire logic        sample_en,
   input wire logic        conv_irq_req
);
   logic [6:0] ctrl_ff;
   logic       samp_ff, seen_ff, rise, run, mode, ctl_wr;
   logic [2:0] last_ff, ext_ff, grp;
   assign rise = sample_en & ~samp_ff;
   assign run = ctrl_ff[CTRL_START_BIT];
   assign mode = ctrl_ff[CTRL_MODE_BIT];
   assign grp = {1'h0, ctrl_ff[CTRL_GRP_LSB+:2]};
   assign ctl_wr = reg_wr && reg_addr == ADDR_CTRL;
   // Control shadow; expected extra channel is set on the first sample of a run
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff <= CTRL_RESET;
         samp_ff <= 1'h0;
         seen_ff <= 1'h0;
         last_ff <= CH_ZERO;
         ext_ff <= CH_ZERO;
      end else begin
         samp_ff <= sample_en;
         if (ctl_wr) ctrl_ff <= reg_wdata[CTRL_WIDTH-1:0];
         if (!run) seen_ff <= 1'h0;
         else if (rise) begin
            seen_ff <= 1'h1;
            last_ff <= mux_sel;
            if (!seen_ff || mux_sel == CH_LAST) ext_ff <= grp + 3'h1;
            else if (mux_sel > grp) ext_ff <= mux_sel + 3'h1;
         end
      end
   end
   // ====================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   irq_low_a: assert property (conv_irq_req == 1'h0)
      else $error("completion request raised");
   start_ch0_a: assert property (ctl_wr && reg_wdata[CTRL_START_BIT] && !run
      |-> ##[1:12] (sample_en && mux_sel == CH_ZERO)) else $error("sweep did not start at channel 0");
   stop_halt_a: assert property (ctl_wr && !reg_wdata[CTRL_START_BIT]
      |-> ##2 (!sample_en) [*8]) else $error("sampling after stop");
   sar_preset_a: assert property (run && rise |-> ##[0:12] dac_code == SAR_PRESET)
      else $error("approximation not preset");
   group0_bound_a: assert property (run && !mode && sample_en |-> mux_sel <= {grp[1:0], 1'h1})
      else $error("channel outside group");
   sweep0_order_a: assert property (run && !mode && rise && seen_ff
      |-> mux_sel == (last_ff == {grp[1:0], 1'h1} ? CH_ZERO : last_ff + 3'h1)) else $error("sweep 0 order");
   sweep1_order_a: assert property (run && mode && rise && seen_ff
      |-> mux_sel == (last_ff < grp ? last_ff + 3'h1 : (last_ff == grp ? ext_ff : CH_ZERO)))
      else $error("sweep 1 order");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   cover property (run && mode && rise && mux_sel == CH_LAST);
   cover property (run && !mode && rise && mux_sel == CH_LAST);
   cover property (run && ctrl_ff[CTRL_RES8_BIT] && rise);
endmodule

// ---- tb/analog_front_model.sv ----
// Analog inputs and comparator facing the sequencer
`timescale 1ns/100ps
module analog_front_model #(
   parameter logic [9:0] VIN_BASE = 10'h05A,
   parameter logic [9:0] VIN_STEP = 10'h071
) (
   // Converter side
   input wire logic [9:0] dac_code,
   input wire logic [2:0] mux_sel,
   output logic           cmp_ref_below
);
   logic [9:0] sampled_input_voltage;
   assign sampled_input_voltage = VIN_BASE + VIN_STEP * {7'h00, mux_sel};
   // No key-input interrupt shares these channels
   // Inputs sit on code centres; reference is half a step under code n
   assign cmp_ref_below = (dac_code == 10'h000) || (dac_code <= sampled_input_voltage);
endmodule

// ---- tb/sar_adc_sweep_sequencer_tb_top.sv ----
// Self-checking bench for the sweep sequencer
`timescale 1ns/100ps
module sar_adc_sweep_sequencer_tb_top;
   import sweep_pkg::*;
   localparam logic [9:0] VIN_BASE = 10'h05A;
   localparam logic [9:0] VIN_STEP = 10'h071;
   logic        mclk, arst_n, reg_wr, reg_rd, cmp_ref_below, sample_en, conv_irq_req;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [9:0]  dac_code;
   logic [2:0]  mux_sel;
   logic        samp_q = 1'h0;
   int          fails = 0, total_checks = 0, cyc = 0;
   logic [2:0]  seq_q[$];
   int          stamp_q[$];
   sar_adc_sweep_sequencer u_sar_adc_sweep_sequencer (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cmp_ref_below(cmp_ref_below), .dac_code(dac_code), .mux_sel(mux_sel), .sample_en(sample_en),
      .conv_irq_req(conv_irq_req));
   analog_front_model #(.VIN_BASE(VIN_BASE), .VIN_STEP(VIN_STEP)) u_analog_front_model (
      .dac_code(dac_code), .mux_sel(mux_sel), .cmp_ref_below(cmp_ref_below));
   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end
   // Log channel and time of every sampling start
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      samp_q <= sample_en;
      if (sample_en && !samp_q) begin
         seq_q.push_back(mux_sel);
         stamp_q.push_back(cyc);
      end
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
      @(posedge mclk);
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] ctl(logic s, logic m, logic [1:0] g, clk_div_t dv, logic r8);
      return {9'h000, r8, dv, g, m, s};
   endfunction
   task automatic wait_rises(input int t);
      int k;
      k = 0;
      while (seq_q.size() < t && k < 4000) begin
         @(posedge mclk);
         k++;
      end
   endtask
   // Run one sweep, then judge order, results and halt
   task automatic run_sweep(input logic m, input logic [1:0] g, input clk_div_t dv, input logic r8, input int n);
      logic [2:0]  ch, ext;
      logic [7:0]  hit;
      logic [9:0]  v;
      logic [15:0] d;
      int          b;
      wr(ADDR_CTRL, ctl(1'h0, m, g, dv, r8));
      repeat (125) @(posedge mclk);
      b = seq_q.size();
      wr(ADDR_CTRL, ctl(1'h1, m, g, dv, r8));
      wait_rises(b + n + 1);
      wr(ADDR_CTRL, ctl(1'h0, m, g, dv, r8));
      ch = CH_ZERO;
      ext = {1'h0, g} + 3'h1;
      hit = 8'h00;
      for (int i = 0; i < n; i++) begin
         chk("channel order", {13'h0000, ch}, {13'h0000, seq_q[b+i]});
         hit[ch] = 1'h1;
         if (!m) ch = (ch == {g, 1'h1}) ? CH_ZERO : ch + 3'h1;
         else if (ch < {1'h0, g}) ch = ch + 3'h1;
         else if (ch == {1'h0, g}) ch = ext;
         else begin
            ch = CH_ZERO;
            ext = (ext == CH_LAST) ? {1'h0, g} + 3'h1 : ext + 3'h1;
         end
      end
      repeat (40) @(posedge mclk);
      chk("sample count after stop", 16'(b + n + 1), 16'(seq_q.size()));
      chk("completion request", 16'h0000, {15'h0000, conv_irq_req});
      for (int c = 0; c < 8; c++) if (hit[c]) begin
         v = VIN_BASE + VIN_STEP * 10'(c);
         rd(ADDR_RESULT0 + 4'(c), d);
         chk("result", r8 ? {8'h00, v[9:2]} : {6'h00, v}, d);
      end
      $display("sweep mode %0d group %0d done", m, g);
   endtask
   task automatic t_reset();
      logic [15:0] d;
      rd(ADDR_CTRL, d);
      chk("control reset", {9'h000, CTRL_RESET}, d);
      wr(ADDR_RESULT0, 16'h0155);
      rd(ADDR_RESULT0, d);
      chk("result write ignored", {6'h00, RES_RESET}, d);
      rd(4'h3, d);
      chk("unmapped read", 16'h0000, d);
      $display("reset test done");
   endtask
   task automatic t_sweeps();
      for (int g = 0; g < 4; g++) run_sweep(SWEEP0, 2'(g), DIV_BY4, 1'h0, 10);
      for (int g = 0; g < 4; g++) run_sweep(SWEEP1, 2'(g), DIV_BY3, 1'h0, 26);
      run_sweep(SWEEP0, 2'h3, DIV_BY4, 1'h1, 8);
   endtask
   // Sampling period must shrink with each faster divider setting
   task automatic t_div();
      int per[4];
      int b;
      for (int i = 0; i < 4; i++) begin
         b = seq_q.size();
         wr(ADDR_CTRL, ctl(1'h0, SWEEP0, 2'h0, clk_div_t'(i), 1'h0));
         repeat (125) @(posedge mclk);
         wr(ADDR_CTRL, ctl(1'h1, SWEEP0, 2'h0, clk_div_t'(i), 1'h0));
         wait_rises(b + 3);
         wr(ADDR_CTRL, ctl(1'h0, SWEEP0, 2'h0, clk_div_t'(i), 1'h0));
         per[i] = stamp_q[b+2] - stamp_q[b+1];
      end
      for (int i = 1; i < 4; i++) chk("period shrinks", 16'h0001, {15'h0000, per[i] < per[i-1]});
      $display("divider test done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk);
      fails++;
      final_report();
   end
   initial begin
      arst_n = 1'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      repeat (4) @(posedge mclk);
      arst_n <= 1'h1;
      @(posedge mclk);
      t_reset();
      t_sweeps();
      t_div();
      final_report();
   end
endmodule
bind sar_adc_sweep_sequencer sweep_checker u_sweep_checker (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_ref_below(cmp_ref_below),
   .dac_code(dac_code), .mux_sel(mux_sel), .sample_en(sample_en), .conv_irq_req(conv_irq_req));
